// ===== src/fsp_pkg.sv
`timescale 1ns/1ps
package fsp_pkg;

	// opcodes handled inside the block
	localparam logic [7:0] OP_WR_ENABLE   = 8'h06;
	localparam logic [7:0] OP_WR_DISABLE  = 8'h04;
	localparam logic [7:0] OP_ENTER_LP    = 8'hB9;
	localparam logic [7:0] OP_RELEASE_LP  = 8'hAB;
	localparam logic [7:0] OP_SRP_NV      = 8'h65;
	localparam logic [7:0] OP_SRP_V_WE    = 8'h63;
	localparam logic [7:0] OP_SRP_V       = 8'hC0;
	localparam logic [7:0] OP_SERP_NV     = 8'h85;
	localparam logic [7:0] OP_SERP_V      = 8'h83;
	localparam logic [7:0] OP_SUSP_A      = 8'h75;
	localparam logic [7:0] OP_SUSP_B      = 8'hB0;
	localparam logic [7:0] OP_RESUME_A    = 8'h7A;
	localparam logic [7:0] OP_RESUME_B    = 8'h30;
	localparam logic [7:0] OP_WIDE_ON     = 8'hB7;
	localparam logic [7:0] OP_WIDE_OFF    = 8'h29;
	localparam logic [7:0] OP_RD_RP       = 8'h61;
	localparam logic [7:0] OP_RD_ERP      = 8'h81;

	// read parameter register layout
	localparam int RP_WRAP_LEN_LSB = 0;
	localparam int RP_WRAP_EN_BIT  = 2;
	localparam int RP_DUMMY_LSB    = 3;
	localparam int RP_HOLD_SEL_BIT = 7;
	// extended read register layout
	localparam int ERP_DRIVE_LSB   = 5;

	// shifting
	localparam logic [3:0] BYTE_BITS    = 4'h8;
	localparam logic [3:0] STEP_SINGLE  = 4'h1;
	localparam logic [3:0] STEP_QUAD    = 4'h4;
	localparam logic [7:0] WRAP_MIN_LEN = 8'h08;
	localparam logic [7:0] ADDR_ONE     = 8'h01;
	localparam logic [3:0] OE_N_SINGLE  = 4'hD;
	localparam logic [3:0] OE_N_QUAD    = 4'h0;
	localparam logic [3:0] OE_N_OFF     = 4'hF;

	// low-power timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int T_ENTRY_NS    = 3000;
	localparam int T_RELEASE_NS  = 5000;
	localparam logic [15:0] ENTRY_CYC   = 16'((T_ENTRY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [15:0] RELEASE_CYC = 16'((T_RELEASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [15:0] CNT_ONE     = 16'h0001;

	// pin synchroniser idle values: ce_n high, sck and io low
	localparam logic [5:0] PIN_IDLE = 6'h20;

	typedef enum logic [1:0] {
		PD_ACTIVE,
		PD_ENTERING,
		PD_DOWN,
		PD_RELEASING
	} fsp_pd_state_t;

	typedef enum logic [1:0] {
		SUS_NONE,
		SUS_ANY,
		SUS_ERASE_ONLY
	} fsp_sus_class_t;

endpackage : fsp_pkg

module fsp_sync #(
	parameter int         W   = 6,
	parameter logic [5:0] RST = 6'h20
) (
	// clock and reset
	input  wire logic         clk_sys,
	input  wire logic         arst_n,
	// data
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_q;

	genvar gi;
	generate
		for (gi = 0; gi < W; gi++) begin : g_bit
			always_ff @(posedge clk_sys or negedge arst_n) begin
				if (!arst_n) begin
					meta_q[gi] <= RST[gi];
					q[gi]      <= RST[gi];
				end else begin
					meta_q[gi] <= d[gi];
					q[gi]      <= meta_q[gi];
				end
			end
		end
	endgenerate
endmodule : fsp_sync

// ===== src/fsp_cmd_core.sv
// Function
// - In either suspend accept resume and temporary read/extended parameter set commands.
// - In either suspend accept enter and exit wide address commands.
// - In either suspend accept protection bit, password, lock and configuration reads.
// - In either suspend accept training pattern and correction register access.
// - Only in erase suspend accept page program commands, all forms.
// - Only in erase suspend accept sector lock and unlock commands.
// - Only in erase suspend accept dynamic protection and correction writes.
// - Low power entry needs full opcode then chip select rise; then entry delay.
// - In low power ignore everything; once fully down accept only the release command.
// - Release completes after release delay; host keeps chip select high meanwhile.
// - Release while write in progress is ignored.
// - Read parameters: wrap field low three bits, dummy field four bits above.
// - Top bit picks reset or hold for shared pin; dedicated pin ignores it.
// - Persistent read parameter set needs latch set; updates both copies.
// - Code 63h needs latch set; code C0h needs none, latch stays.
// - Wrap disabled: address increments through the whole array.
// - Values 0-3 continuous; 4-7 wrap of 8, 16, 32, 64 bytes.
// - Wrap advances inside aligned boundary within page, back to start.
// - Wrap stays until cleared by parameter write, low power or reset.
// - With wrap enabled every read uses wrapped addressing.
// - Extended register holds three bit drive field, default half strength.
// - Persistent extended set updates both copies; temporary only temporary.
// - Quad mode: each byte is two nibbles, high nibble first.
// - Suspend sets matching suspended flag and clears write enable latch.
`timescale 1ns/1ps
module fsp_cmd_core #(
	parameter int         ADDR_W         = 26,
	parameter logic [7:0] RP_NV_INIT     = 8'h00,
	parameter logic [2:0] DRIVE_HALF     = 3'h0,
	parameter bit         HAS_RESET_PIN  = 1'b0
) (
	// clock and reset
	input  wire logic              clk_sys,
	input  wire logic              arst_n,
	// link pins
	input  wire logic              ce_n_pin,
	input  wire logic              sck_pin,
	input  wire logic [3:0]        io_i,
	output logic      [3:0]        io_o_q,
	output logic      [3:0]        io_oe_n_q,
	// core status
	input  wire logic              quad_mode,
	input  wire logic              write_in_progress,
	input  wire logic              erase_busy,
	input  wire logic              program_busy,
	// accepted command report
	output logic                   cmd_strobe_q,
	output logic      [7:0]        cmd_code_q,
	// status
	output logic                   write_enable_latch_q,
	output logic                   erase_suspended_flag_q,
	output logic                   program_suspended_flag_q,
	output logic                   low_power_q,
	output logic                   wide_address_q,
	// read configuration
	output logic      [7:0]        read_parameter_register_q,
	output logic      [7:0]        ext_read_register_q,
	output logic                   hold_pin_is_reset_q,
	// read address sequencer
	input  wire logic              addr_load,
	input  wire logic [ADDR_W-1:0] addr_in,
	input  wire logic              addr_step,
	output logic      [ADDR_W-1:0] addr_q
);
	logic [5:0]                   pins_s;
	logic                         ce_s;
	logic                         sck_s;
	logic [3:0]                   io_s;
	logic                         ce_prev_q;
	logic                         sck_prev_q;
	logic                         sck_rise;
	logic                         sck_fall;
	logic                         ce_rise;
	logic                         ce_fall;
	logic [7:0]                   sh_q;
	logic [7:0]                   sh_d;
	logic [3:0]                   bits_q;
	logic [3:0]                   bits_d;
	logic [7:0]                   op_q;
	logic [7:0]                   data_q;
	logic                         have_op_q;
	logic                         have_data_q;
	logic                         op_now;
	logic                         exec;
	logic                         exec_ok;
	logic                         new_op_ok;
	logic [7:0]                   nv_rp_q;
	logic [7:0]                   v_rp_q;
	logic [7:0]                   nv_erp_q;
	logic [7:0]                   v_erp_q;
	logic [7:0]                   act_rp_q;
	fsp_pkg::fsp_pd_state_t       pd_q;
	logic [15:0]                  pd_cnt_q;
	logic                         pd_clear_wrap;
	logic [7:0]                   out_sh_q;
	logic                         out_act_q;
	logic [7:0]                   wrap_mask;
	logic [7:0]                   addr_lo_inc;

	localparam logic [7:0] ERP_INIT = {DRIVE_HALF, 5'h00};

	// suspend class of an opcode
	function automatic fsp_pkg::fsp_sus_class_t sus_class(input logic [7:0] code);
		fsp_pkg::fsp_sus_class_t c;
		c = fsp_pkg::SUS_NONE;
		case (code)
			// reads, latch, status and id commands
			8'h03, 8'h13, 8'h0B, 8'h0C, 8'hBB, 8'hBC, 8'h3B, 8'h3C, 8'hEB, 8'hEC,
			8'h6B, 8'h6C, 8'h0D, 8'h0E, 8'hBD, 8'hBE, 8'hED, 8'hEE, 8'h06, 8'h04,
			8'h05, 8'h48, 8'h16, 8'hC8, 8'h61, 8'h81, 8'hAB, 8'h9F, 8'h90, 8'hAF,
			8'h4B, 8'h5A, 8'h82, 8'h17, 8'hC5: c = fsp_pkg::SUS_ANY;
			8'h7A, 8'h30, 8'hC0, 8'h63, 8'h83: c = fsp_pkg::SUS_ANY;
			8'hB7, 8'h29: c = fsp_pkg::SUS_ANY;
			8'hFC, 8'hF2, 8'hFA, 8'hE0, 8'hE7, 8'hA7, 8'h2B: c = fsp_pkg::SUS_ANY;
			8'h41, 8'h4A, 8'hB6, 8'hB3: c = fsp_pkg::SUS_ANY;
			8'h02, 8'h12, 8'h32, 8'h38, 8'h34, 8'h3E: c = fsp_pkg::SUS_ERASE_ONLY;
			8'h24, 8'h26, 8'h25: c = fsp_pkg::SUS_ERASE_ONLY;
			8'hFB, 8'hB5, 8'h75, 8'hB0: c = fsp_pkg::SUS_ERASE_ONLY;
			default: c = fsp_pkg::SUS_NONE;
		endcase
		return c;
	endfunction : sus_class

	function automatic logic permit(input logic [7:0] code, input fsp_pkg::fsp_pd_state_t st,
		input logic erase_suspended_flag, input logic program_suspended_flag);
		fsp_pkg::fsp_sus_class_t c;
		logic ok;
		c  = sus_class(code);
		ok = 1'b0;
		if (st == fsp_pkg::PD_DOWN) begin
			ok = (code == fsp_pkg::OP_RELEASE_LP);
		end else if (st == fsp_pkg::PD_ACTIVE) begin
			if (!erase_suspended_flag && !program_suspended_flag) begin
				ok = 1'b1;
			end else begin
				ok = (c == fsp_pkg::SUS_ANY) || (c == fsp_pkg::SUS_ERASE_ONLY && erase_suspended_flag);
			end
		end
		return ok;
	endfunction : permit

	fsp_sync #(
		.W   (6),
		.RST (fsp_pkg::PIN_IDLE)
	) u_sync (
		.clk_sys (clk_sys),
		.arst_n  (arst_n),
		.d       ({ce_n_pin, sck_pin, io_i}),
		.q       (pins_s)
	);

	assign ce_s     = pins_s[5];
	assign sck_s    = pins_s[4];
	assign io_s     = pins_s[3:0];
	assign sck_rise = sck_s & ~sck_prev_q;
	assign sck_fall = ~sck_s & sck_prev_q;
	assign ce_rise  = ce_s & ~ce_prev_q;
	assign ce_fall  = ~ce_s & ce_prev_q;

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			ce_prev_q  <= 1'b1;
			sck_prev_q <= 1'b0;
		end else begin
			ce_prev_q  <= ce_s;
			sck_prev_q <= sck_s;
		end
	end

	// quad takes a nibble per clock, high nibble first
	always_comb begin
		if (quad_mode) begin
			sh_d   = {sh_q[3:0], io_s};
			bits_d = bits_q + fsp_pkg::STEP_QUAD;
		end else begin
			sh_d   = {sh_q[6:0], io_s[0]};
			bits_d = bits_q + fsp_pkg::STEP_SINGLE;
		end
	end

	assign op_now    = sck_rise & ~ce_s & ~have_op_q & (bits_d == fsp_pkg::BYTE_BITS);
	// only a whole opcode followed by chip select rise executes
	assign exec      = ce_rise & have_op_q;
	assign exec_ok   = exec & permit(op_q, pd_q, erase_suspended_flag_q, program_suspended_flag_q)
		& ~(pd_q == fsp_pkg::PD_DOWN && write_in_progress);
	assign new_op_ok = permit(sh_d, pd_q, erase_suspended_flag_q, program_suspended_flag_q);

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			sh_q        <= 8'h00;
			bits_q      <= 4'h0;
			op_q        <= 8'h00;
			data_q      <= 8'h00;
			have_op_q   <= 1'b0;
			have_data_q <= 1'b0;
		end else if (ce_rise || ce_fall) begin
			bits_q      <= 4'h0;
			have_op_q   <= 1'b0;
			have_data_q <= 1'b0;
		end else if (sck_rise && !ce_s) begin
			sh_q <= sh_d;
			if (bits_d == fsp_pkg::BYTE_BITS) begin
				bits_q <= 4'h0;
				if (!have_op_q) begin
					op_q      <= sh_d;
					have_op_q <= 1'b1;
				end else if (!have_data_q) begin
					data_q      <= sh_d;
					have_data_q <= 1'b1;
				end
			end else begin
				bits_q <= bits_d;
			end
		end
	end

	// write enable latch, suspend flags, address width
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			write_enable_latch_q     <= 1'b0;
			erase_suspended_flag_q   <= 1'b0;
			program_suspended_flag_q <= 1'b0;
			wide_address_q           <= 1'b0;
		end else if (exec_ok) begin
			unique case (op_q)
				fsp_pkg::OP_WR_ENABLE: begin
					write_enable_latch_q <= 1'b1;
				end
				fsp_pkg::OP_WR_DISABLE: begin
					write_enable_latch_q <= 1'b0;
				end
				fsp_pkg::OP_SRP_NV, fsp_pkg::OP_SRP_V_WE: begin
					if (have_data_q) begin
						write_enable_latch_q <= 1'b0;
					end
				end
				fsp_pkg::OP_SUSP_A, fsp_pkg::OP_SUSP_B: begin
					if (erase_busy) begin
						erase_suspended_flag_q <= 1'b1;
						write_enable_latch_q   <= 1'b0;
					end else if (program_busy) begin
						program_suspended_flag_q <= 1'b1;
						write_enable_latch_q     <= 1'b0;
					end
				end
				fsp_pkg::OP_RESUME_A, fsp_pkg::OP_RESUME_B: begin
					erase_suspended_flag_q   <= 1'b0;
					program_suspended_flag_q <= 1'b0;
				end
				fsp_pkg::OP_WIDE_ON: begin
					wide_address_q <= 1'b1;
				end
				fsp_pkg::OP_WIDE_OFF: begin
					wide_address_q <= 1'b0;
				end
				default: begin
				end
			endcase
		end
	end

	// parameter registers; C0h leaves the latch alone
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			nv_rp_q  <= RP_NV_INIT;
			v_rp_q   <= RP_NV_INIT;
			nv_erp_q <= ERP_INIT;
			v_erp_q  <= ERP_INIT;
		end else if (pd_clear_wrap) begin
			v_rp_q[fsp_pkg::RP_WRAP_EN_BIT] <= 1'b0;
		end else if (exec_ok && have_data_q) begin
			unique case (op_q)
				fsp_pkg::OP_SRP_NV: begin
					if (write_enable_latch_q) begin
						nv_rp_q <= data_q;
						v_rp_q  <= data_q;
					end
				end
				fsp_pkg::OP_SRP_V_WE: begin
					if (write_enable_latch_q) begin
						v_rp_q <= data_q;
					end
				end
				fsp_pkg::OP_SRP_V: begin
					v_rp_q <= data_q;
				end
				fsp_pkg::OP_SERP_NV: begin
					nv_erp_q <= data_q;
					v_erp_q  <= data_q;
				end
				fsp_pkg::OP_SERP_V: begin
					v_erp_q <= data_q;
				end
				default: begin
				end
			endcase
		end
	end

	// a frame in flight keeps the parameters it started with
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			act_rp_q <= RP_NV_INIT;
		end else if (op_now) begin
			act_rp_q <= v_rp_q;
		end
	end

	assign read_parameter_register_q = act_rp_q;
	assign ext_read_register_q       = v_erp_q;

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			hold_pin_is_reset_q <= 1'b0;
		end else begin
			hold_pin_is_reset_q <= ~HAS_RESET_PIN & v_rp_q[fsp_pkg::RP_HOLD_SEL_BIT];
		end
	end

	// low power sequencing
	assign pd_clear_wrap = (pd_q == fsp_pkg::PD_ENTERING) && (pd_cnt_q == 16'h0000);

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			pd_q     <= fsp_pkg::PD_ACTIVE;
			pd_cnt_q <= 16'h0000;
		end else begin
			unique case (pd_q)
				fsp_pkg::PD_ACTIVE: begin
					if (exec_ok && op_q == fsp_pkg::OP_ENTER_LP) begin
						pd_q     <= fsp_pkg::PD_ENTERING;
						pd_cnt_q <= fsp_pkg::ENTRY_CYC - fsp_pkg::CNT_ONE;
					end
				end
				fsp_pkg::PD_ENTERING: begin
					if (pd_cnt_q == 16'h0000) begin
						pd_q <= fsp_pkg::PD_DOWN;
					end else begin
						pd_cnt_q <= pd_cnt_q - fsp_pkg::CNT_ONE;
					end
				end
				fsp_pkg::PD_DOWN: begin
					if (exec_ok && !write_in_progress) begin
						pd_q     <= fsp_pkg::PD_RELEASING;
						pd_cnt_q <= fsp_pkg::RELEASE_CYC - fsp_pkg::CNT_ONE;
					end
				end
				fsp_pkg::PD_RELEASING: begin
					// frames during the delay are dropped, the host must wait
					if (pd_cnt_q == 16'h0000) begin
						pd_q <= fsp_pkg::PD_ACTIVE;
					end else begin
						pd_cnt_q <= pd_cnt_q - fsp_pkg::CNT_ONE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			low_power_q <= 1'b0;
		end else begin
			low_power_q <= (pd_q != fsp_pkg::PD_ACTIVE);
		end
	end

	// report of every command that survived filtering
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			cmd_strobe_q <= 1'b0;
			cmd_code_q   <= 8'h00;
		end else begin
			cmd_strobe_q <= exec_ok;
			if (exec_ok) begin
				cmd_code_q <= op_q;
			end
		end
	end

	// register readback, shifted out on falling sck
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			out_sh_q  <= 8'h00;
			out_act_q <= 1'b0;
			io_o_q    <= 4'h0;
			io_oe_n_q <= fsp_pkg::OE_N_OFF;
		end else if (ce_s) begin
			out_act_q <= 1'b0;
			io_oe_n_q <= fsp_pkg::OE_N_OFF;
		end else if (op_now && new_op_ok && pd_q == fsp_pkg::PD_ACTIVE) begin
			if (sh_d == fsp_pkg::OP_RD_RP) begin
				out_sh_q  <= v_rp_q;
				out_act_q <= 1'b1;
			end else if (sh_d == fsp_pkg::OP_RD_ERP) begin
				out_sh_q  <= v_erp_q;
				out_act_q <= 1'b1;
			end
		end else if (sck_fall && out_act_q) begin
			if (quad_mode) begin
				io_o_q    <= out_sh_q[7:4];
				io_oe_n_q <= fsp_pkg::OE_N_QUAD;
				out_sh_q  <= {out_sh_q[3:0], out_sh_q[7:4]};
			end else begin
				io_o_q    <= {2'b00, out_sh_q[7], 1'b0};
				io_oe_n_q <= fsp_pkg::OE_N_SINGLE;
				out_sh_q  <= {out_sh_q[6:0], out_sh_q[7]};
			end
		end
	end

	// wrap length 8 << sel, boundary aligned inside the page
	assign wrap_mask   = (fsp_pkg::WRAP_MIN_LEN << act_rp_q[fsp_pkg::RP_WRAP_LEN_LSB +: 2])
		- fsp_pkg::ADDR_ONE;
	assign addr_lo_inc = addr_q[7:0] + fsp_pkg::ADDR_ONE;

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			addr_q <= '0;
		end else if (addr_load) begin
			addr_q <= addr_in;
		end else if (addr_step) begin
			if (act_rp_q[fsp_pkg::RP_WRAP_EN_BIT]) begin
				addr_q[7:0] <= (addr_q[7:0] & ~wrap_mask) | (addr_lo_inc & wrap_mask);
			end else begin
				addr_q <= addr_q + ADDR_W'(1);
			end
		end
	end

endmodule : fsp_cmd_core

// ===== bench/fsp_cmd_core_props.sv
`timescale 1ns/1ps
module fsp_cmd_core_props #(
	parameter int ADDR_W = 26
) (
	// clock and reset
	input wire logic              clk_sys,
	input wire logic              arst_n,
	// link and status
	input wire logic              ce_n_pin,
	input wire logic              cmd_strobe_q,
	input wire logic [7:0]        cmd_code_q,
	input wire logic              write_enable_latch_q,
	input wire logic              erase_suspended_flag_q,
	input wire logic              program_suspended_flag_q,
	input wire logic              low_power_q,
	input wire logic              wide_address_q,
	input wire logic [7:0]        read_parameter_register_q,
	// address sequencer
	input wire logic              addr_load,
	input wire logic [ADDR_W-1:0] addr_in,
	input wire logic              addr_step,
	input wire logic [ADDR_W-1:0] addr_q
);
	logic [ADDR_W-1:0] wmask;
	logic [ADDR_W-1:0] one;
	// wrap block spans 8 << len bytes
	assign wmask = ADDR_W'((9'h008 << read_parameter_register_q[1:0]) - 9'h001);
	assign one   = ADDR_W'(32'h1);

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);

	chk_strobe_after_select: assert property (cmd_strobe_q |-> ce_n_pin && $past(ce_n_pin, 2))
		else $error("command strobe while chip select low");
	chk_entry_cause: assert property ($rose(low_power_q) |->
		$past(cmd_strobe_q) && cmd_code_q == fsp_pkg::OP_ENTER_LP)
		else $error("low power without entry command");
	chk_down_ignores: assert property (low_power_q && $past(low_power_q) && cmd_strobe_q |-> cmd_code_q == fsp_pkg::OP_RELEASE_LP)
		else $error("command accepted in low power");
	chk_suspend_latch: assert property ($rose(erase_suspended_flag_q) || $rose(program_suspended_flag_q) |-> !write_enable_latch_q)
		else $error("latch set after suspend");
	chk_free_code_latch: assert property (cmd_strobe_q && cmd_code_q == fsp_pkg::OP_SRP_V && !$past(write_enable_latch_q) |-> !write_enable_latch_q)
		else $error("latch set by free parameter write");
	chk_wide_on: assert property (cmd_strobe_q && cmd_code_q == fsp_pkg::OP_WIDE_ON |-> wide_address_q)
		else $error("wide address not entered");
	chk_wide_off: assert property (cmd_strobe_q && cmd_code_q == fsp_pkg::OP_WIDE_OFF |-> !wide_address_q)
		else $error("wide address not left");
	chk_resume_clears: assert property (cmd_strobe_q && (cmd_code_q == fsp_pkg::OP_RESUME_A || cmd_code_q == fsp_pkg::OP_RESUME_B) |-> !erase_suspended_flag_q && !program_suspended_flag_q)
		else $error("suspend flag kept after resume");
	chk_wrap_step: assert property (addr_step && !addr_load && read_parameter_register_q[2] |=> ((addr_q ^ $past(addr_q)) & ~$past(wmask)) == '0 && (addr_q & $past(wmask)) == (($past(addr_q) + one) & $past(wmask)))
		else $error("wrapped step left its block");
	chk_flat_step: assert property (addr_step && !addr_load && !read_parameter_register_q[2] |=> addr_q == $past(addr_q) + one)
		else $error("flat step not by one");
	chk_load_start: assert property (addr_load |=> addr_q == $past(addr_in))
		else $error("start address not loaded");
endmodule : fsp_cmd_core_props

bind fsp_cmd_core fsp_cmd_core_props #(.ADDR_W(ADDR_W)) u_props (
	.clk_sys, .arst_n, .ce_n_pin, .cmd_strobe_q, .cmd_code_q, .write_enable_latch_q,
	.erase_suspended_flag_q, .program_suspended_flag_q, .low_power_q, .wide_address_q,
	.read_parameter_register_q, .addr_load, .addr_in, .addr_step, .addr_q
);

// ===== bench/fsp_host.sv
`timescale 1ns/1ps
module fsp_host (
	// link pins
	output logic       ce_n,
	output logic       sck,
	output logic [3:0] io,
	// command mode
	input  wire logic  quad
);
	initial begin
		ce_n = 1'b1;
		sck  = 1'b0;
		io   = 4'h0;
	end

	// sck stands low between frames; chip select rises only after whole bytes
	task automatic send(input logic [7:0] op, input logic [7:0] dat, input bit with_data);
		logic [15:0] bits;
		int          n;
		bits = {op, dat};
		n = 0;
		ce_n = 1'b0;
		#80;
		while (n < (with_data ? 16 : 8)) begin
			io = quad ? bits[15-n -: 4] : {3'h0, bits[15-n]};
			#80 sck = 1'b1;
			#80 sck = 1'b0;
			n = n + (quad ? 4 : 1);
		end
		#40 ce_n = 1'b1;
		// released lines must not keep showing the last bit
		io = ~io;
		#400;
	endtask : send
endmodule : fsp_host

// ===== bench/tb_fsp_cmd_core.sv
`timescale 1ns/1ps
module tb_fsp_cmd_core;
	localparam int         AW = 26;
	localparam logic [7:0] ERASE_ONLY [9]  = '{8'h02, 8'h12, 8'h32, 8'h38, 8'h24, 8'h26, 8'h25,
		8'hFB, 8'hB5};
	localparam logic [7:0] EITHER     [12] = '{8'hB7, 8'h29, 8'hFC, 8'hF2, 8'hFA, 8'hE7, 8'hA7,
		8'h2B, 8'h41, 8'h4A, 8'hB6, 8'hB3};
	logic          clk_sys, arst_n, ce_n_pin, sck_pin, quad_mode, write_in_progress, fired;
	logic          erase_busy, program_busy, addr_load, addr_step, cmd_strobe_q;
	logic          write_enable_latch_q, erase_suspended_flag_q, program_suspended_flag_q;
	logic          low_power_q, hold_reset;
	logic [3:0]    io_i, io_o, io_oe_n;
	logic [7:0]    cmd_code_q, last_code, read_parameter_register_q, ext_read_register_q, rb;
	logic [AW-1:0] addr_in, addr_q;
	int            errors = 0, num_checks = 0, seen = 0, cyc = 0;

	fsp_cmd_core #(.ADDR_W(AW)) DUT (
		.clk_sys, .arst_n, .ce_n_pin, .sck_pin, .io_i, .io_o_q(io_o), .io_oe_n_q(io_oe_n), .quad_mode,
		.write_in_progress, .erase_busy, .program_busy, .cmd_strobe_q, .cmd_code_q,
		.write_enable_latch_q, .erase_suspended_flag_q, .program_suspended_flag_q, .low_power_q,
		.wide_address_q(), .read_parameter_register_q, .ext_read_register_q,
		.hold_pin_is_reset_q(hold_reset), .addr_load, .addr_in, .addr_step, .addr_q
	);
	fsp_host host (.ce_n(ce_n_pin), .sck(sck_pin), .io(io_i), .quad(quad_mode));

	// readback bits settle well before the host's next rising sck
	always @(posedge sck_pin) begin
		if (io_oe_n === fsp_pkg::OE_N_SINGLE) begin
			rb = {rb[6:0], io_o[1]};
		end else if (io_oe_n === fsp_pkg::OE_N_QUAD) begin
			rb = {rb[3:0], io_o};
		end
	end

	always #5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cyc++;
		if (cmd_strobe_q === 1'b1) begin
			seen++;
			last_code = cmd_code_q;
		end
		if (cyc == 40000) begin
			errors++;
			final_report();
		end
	end

	task automatic final_report();
		if (errors == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : final_report

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic cmd(input logic [7:0] op, input logic [7:0] dat, input bit with_data);
		int s0;
		s0 = seen;
		host.send(op, dat, with_data);
		fired = (seen != s0);
	endtask : cmd

	task automatic walk(input logic [AW-1:0] a, input int n, input logic [15:0] exp);
		@(posedge clk_sys);
		#1 addr_in = a;
		addr_load = 1'b1;
		@(posedge clk_sys);
		#1 addr_load = 1'b0;
		addr_step = 1'b1;
		repeat (n) @(posedge clk_sys);
		#1 addr_step = 1'b0;
		check(addr_q[15:0], exp);
	endtask : walk

	task automatic t_params();
		cmd(fsp_pkg::OP_SRP_V, 8'h05, 1'b1);
		check(16'({fired, write_enable_latch_q}), 16'h0002);
		cmd(fsp_pkg::OP_WR_DISABLE, 8'h00, 1'b0);
		check(16'(read_parameter_register_q), 16'h0005);
		walk(26'h00000FE, 2, 16'h00F0);
		cmd(fsp_pkg::OP_SRP_V_WE, 8'h04, 1'b1);
		cmd(fsp_pkg::OP_WR_DISABLE, 8'h00, 1'b0);
		check(16'(read_parameter_register_q), 16'h0005);
		cmd(fsp_pkg::OP_WR_ENABLE, 8'h00, 1'b0);
		cmd(fsp_pkg::OP_SRP_V_WE, 8'h04, 1'b1);
		cmd(fsp_pkg::OP_WR_DISABLE, 8'h00, 1'b0);
		check(16'(read_parameter_register_q), 16'h0004);
		walk(26'h00000FE, 2, 16'h00F8);
		cmd(fsp_pkg::OP_WR_ENABLE, 8'h00, 1'b0);
		cmd(fsp_pkg::OP_SRP_NV, 8'h7B, 1'b1);
		cmd(fsp_pkg::OP_WR_DISABLE, 8'h00, 1'b0);
		check(16'(read_parameter_register_q), 16'h007B);
		walk(26'h00000FE, 2, 16'h0100);
		cmd(fsp_pkg::OP_RD_RP, 8'h00, 1'b1);
		check(16'(rb), 16'h007B);
		cmd(fsp_pkg::OP_SERP_V, 8'hE0, 1'b1);
		check(16'(ext_read_register_q), 16'h00E0);
		cmd(fsp_pkg::OP_SERP_NV, 8'h40, 1'b1);
		check(16'(ext_read_register_q), 16'h0040);
	endtask : t_params

	task automatic sweep(input bit erase_ok);
		foreach (ERASE_ONLY[i]) begin
			cmd(ERASE_ONLY[i], 8'h00, 1'b0);
			check(16'(fired), 16'(erase_ok));
		end
		foreach (EITHER[i]) begin
			cmd(EITHER[i], 8'h00, 1'b0);
			check(16'({fired, last_code}), {8'h01, EITHER[i]});
		end
	endtask : sweep

	task automatic t_suspend();
		@(posedge clk_sys);
		#1 erase_busy = 1'b1;
		cmd(fsp_pkg::OP_WR_ENABLE, 8'h00, 1'b0);
		cmd(fsp_pkg::OP_SUSP_A, 8'h00, 1'b0);
		check(16'({erase_suspended_flag_q, write_enable_latch_q}), 16'h0002);
		sweep(1'b1);
		cmd(fsp_pkg::OP_SERP_V, 8'h60, 1'b1);
		check(16'(ext_read_register_q), 16'h0060);
		cmd(fsp_pkg::OP_RESUME_A, 8'h00, 1'b0);
		check(16'(erase_suspended_flag_q), 16'h0000);
		@(posedge clk_sys);
		#1 erase_busy = 1'b0;
		program_busy = 1'b1;
		cmd(fsp_pkg::OP_SUSP_B, 8'h00, 1'b0);
		check(16'(program_suspended_flag_q), 16'h0001);
		sweep(1'b0);
		cmd(fsp_pkg::OP_SRP_V, 8'hFB, 1'b1);
		check(16'({fired, hold_reset}), 16'h0003);
		cmd(fsp_pkg::OP_RESUME_B, 8'h00, 1'b0);
		check(16'(program_suspended_flag_q), 16'h0000);
		@(posedge clk_sys);
		#1 program_busy = 1'b0;
	endtask : t_suspend

	task automatic t_quad();
		@(posedge clk_sys);
		#1 quad_mode = 1'b1;
		cmd(fsp_pkg::OP_SERP_V, 8'hA0, 1'b1);
		check(16'({fired, ext_read_register_q}), 16'h01A0);
		cmd(fsp_pkg::OP_RD_ERP, 8'h00, 1'b1);
		check(16'(rb), 16'h00A0);
		@(posedge clk_sys);
		#1 quad_mode = 1'b0;
	endtask : t_quad

	task automatic t_low_power();
		cmd(fsp_pkg::OP_SRP_V, 8'h04, 1'b1);
		cmd(fsp_pkg::OP_ENTER_LP, 8'h00, 1'b0);
		check(16'(low_power_q), 16'h0001);
		repeat (310) @(posedge clk_sys);
		cmd(8'h05, 8'h00, 1'b0);
		check(16'(fired), 16'h0000);
		cmd(fsp_pkg::OP_WR_ENABLE, 8'h00, 1'b0);
		check(16'({fired, write_enable_latch_q}), 16'h0000);
		@(posedge clk_sys);
		#1 write_in_progress = 1'b1;
		cmd(fsp_pkg::OP_RELEASE_LP, 8'h00, 1'b0);
		repeat (520) @(posedge clk_sys);
		check(16'({fired, low_power_q}), 16'h0001);
		#1 write_in_progress = 1'b0;
		cmd(fsp_pkg::OP_RELEASE_LP, 8'h00, 1'b0);
		// chip select stays high through the whole release wait
		repeat (400) @(posedge clk_sys);
		check(16'({fired, low_power_q}), 16'h0003);
		repeat (120) @(posedge clk_sys);
		check(16'(low_power_q), 16'h0000);
		cmd(fsp_pkg::OP_WR_DISABLE, 8'h00, 1'b0);
		check(16'(read_parameter_register_q[2]), 16'h0000);
	endtask : t_low_power

	initial begin
		clk_sys = 1'b0;
		arst_n = 1'b0;
		quad_mode = 1'b0;
		write_in_progress = 1'b0;
		erase_busy = 1'b0;
		program_busy = 1'b0;
		addr_load = 1'b0;
		addr_step = 1'b0;
		addr_in = '0;
		repeat (20) @(posedge clk_sys);
		#1 arst_n = 1'b1;
		check({read_parameter_register_q, ext_read_register_q}, 16'h0000);
		t_params();
		t_suspend();
		t_quad();
		t_low_power();
		final_report();
	end
endmodule : tb_fsp_cmd_core
